// [hw/ics_params.svh]
/*
 * Constants of the interrupt context stack: register offsets, field
 * positions, reset values, vector numbers and sizes.
 * Assumes it is included once per compilation unit by its bare name.
 */
// Function
// - Four active-low maskable external requests plus one nonmaskable request input.
// - Serial port, timer and software, trap, nonmaskable instructions raise interrupts.
// - Software interrupt instruction reaches any of 32 vectors by its number.
// - Vectors 0 to 19 reserved for hardware; 20 to 31 free for users.
// - Taking an interrupt pushes the program counter on the shared 8-entry stack.
// - Entry copies eleven core registers into one-deep shadow copies.
// - Shadow copies leave out the global mask bit and external flag bit.
// - Taking any interrupt sets the global mask, blocking maskable requests.
// - Working registers keep their values after the save; handler sees them.
// - Either return-from-interrupt copies every shadow back to its register.
// - Return-from-interrupt also pops the stack top into the program counter.
// - Push and pop move a value between accumulator and stack top.
// - Memory push and pop move a word between data memory and stack top.
// - Reset clears all pending flags and sets the global mask.
// - Reset clears the vector pointer field, putting vectors at address zero.
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH

// Register byte offsets
`define ICS_OFS_MASK      8'h00
`define ICS_OFS_FLAGS     8'h04
`define ICS_OFS_STATUS    8'h08
`define ICS_OFS_VECPTR    8'h0C

// Reset values
`define ICS_RST_MASK      9'h000
`define ICS_RST_VECPTR    5'h00

// Field positions in the status word read back
`define ICS_STAT_GLOBAL_IRQ_MASK     0
`define ICS_STAT_NMI      1
`define ICS_STAT_DEPTH_LO 4

// Field positions inside the core status words
`define ICS_ST0_GLOBAL_IRQ_MASK_BIT  9
`define ICS_ST1_XF_BIT    4

// Vector numbers of the hardware sources
`define ICS_VEC_FIRST_HW  5'h01
`define ICS_VEC_TRAP      5'h11
`define ICS_VEC_NMI       5'h12
`define ICS_VEC_RESERVED  20
`define ICS_NUM_VECTORS   32

// Sizes
`define ICS_NUM_MASKABLE  9
`define ICS_STACK_DEPTH   8
`define ICS_NUM_SHADOWS   11

`endif

// [hw/ics_pkg.sv]
/*
 * Types shared by the interrupt context stack.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ics_pkg;

    // One stack action per cycle, one-hot coded
    typedef enum logic [4:0] {
        ICS_STK_IDLE = 5'b0_0001,
        ICS_STK_PUSH = 5'b0_0010,
        ICS_STK_POP  = 5'b0_0100,
        ICS_STK_PEEK = 5'b0_1000,
        ICS_STK_TAKE = 5'b1_0000
    } ics_stk_op_t;

endpackage : ics_pkg

// [hw/ics_core.sv]
/*
 * Interrupt entry and exit for a 16-bit signal-processor core: request
 * flags, arbitration, the eight-entry return stack, the one-deep shadow
 * copies and the global interrupt mask, plus a small register port.
 * Assumes the core pulses at most one instruction strobe per cycle and
 * that all inputs are synchronous to mclk.
 */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ics_params.svh"

module ics_core
    import ics_pkg::*;
#(
    parameter int STACK_DEPTH = `ICS_STACK_DEPTH,
    parameter int NUM_MASK    = `ICS_NUM_MASKABLE
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Request inputs
    input  wire logic [3:0]  ext_irq_n,
    input  wire logic        nmi_n,
    input  wire logic [4:0]  periph_irq,
    // Instruction strobes from the core
    input  wire logic        soft_interrupt_instr,
    input  wire logic [4:0]  soft_vec,
    input  wire logic        trap_instr,
    input  wire logic        nmi_trigger_instr,
    input  wire logic        return_restore_instr,
    input  wire logic        return_restore_enable_instr,
    input  wire logic        call_instr,
    input  wire logic        ret_instr,
    input  wire logic        push_acc_instr,
    input  wire logic        pop_acc_instr,
    input  wire logic        push_from_memory_instr,
    input  wire logic        pop_to_memory_instr,
    input  wire logic        set_mask_instr,
    input  wire logic        clr_mask_instr,
    input  wire logic [15:0] push_value,
    input  wire logic [15:0] mem_rdata,
    // Live core state
    input  wire logic [15:0] cur_pc,
    input  wire logic [31:0] cur_acc,
    input  wire logic [31:0] cur_accum_buffer,
    input  wire logic [15:0] cur_aux_compare_reg,
    input  wire logic [15:0] cur_index_reg,
    input  wire logic [15:0] cur_mode_status_reg,
    input  wire logic [31:0] cur_product_reg,
    input  wire logic [15:0] cur_status_word_zero,
    input  wire logic [15:0] cur_status_word_one,
    input  wire logic [15:0] cur_mult_temp_reg,
    input  wire logic [15:0] cur_shift_count_reg,
    input  wire logic [15:0] cur_bit_test_reg,
    // Entry and stack results
    output logic             irq_take,
    output logic [15:0]      vector_addr,
    output logic             pc_load,
    output logic             acc_load,
    output logic             mem_write,
    output logic [15:0]      stack_data,
    output logic             global_irq_mask,
    // Context restore
    output logic             restore_valid,
    output logic [31:0]      rst_acc,
    output logic [31:0]      rst_accum_buffer,
    output logic [15:0]      rst_aux_compare_reg,
    output logic [15:0]      rst_index_reg,
    output logic [15:0]      rst_mode_status_reg,
    output logic [31:0]      rst_product_reg,
    output logic [15:0]      rst_status_word_zero,
    output logic [15:0]      rst_status_word_one,
    output logic [15:0]      rst_mult_temp_reg,
    output logic [15:0]      rst_shift_count_reg,
    output logic [15:0]      rst_bit_test_reg,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);

    localparam int SPW = $clog2(STACK_DEPTH);

    logic [3:0]          ext_prev_q;
    logic                nmi_prev_q;
    logic [NUM_MASK-1:0] flags_q;
    logic [NUM_MASK-1:0] mask_q;
    logic                nmi_pend_q;
    logic                global_irq_mask_q;
    logic [4:0]          vecptr_q;
    logic [15:0]         stk_q [STACK_DEPTH];
    logic [SPW-1:0]      sp_q;
    logic [SPW:0]        depth_q;
    logic [31:0]         sh_q [`ICS_NUM_SHADOWS];
    logic [31:0]         ctx_w [`ICS_NUM_SHADOWS];
    logic [NUM_MASK-1:0] flag_set_w;
    logic [NUM_MASK-1:0] flag_clr_w;
    logic [NUM_MASK-1:0] ready_w;
    logic                any_instr_w;
    logic                take_w;
    logic                take_nmi_w;
    logic [4:0]          take_vec_w;
    logic [3:0]          take_idx_w;
    logic                ret_any_w;
    logic                push_w;
    logic                pop_w;
    logic [15:0]         push_val_w;
    ics_stk_op_t         op_w;

    // Lowest set bit wins, so lower vector numbers have priority
    function automatic logic [3:0] ics_first_set(
        input logic [NUM_MASK-1:0] v
    );
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_MASK - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : ics_first_set

    // Bit mask of one position, used for flag clears
    function automatic logic [NUM_MASK-1:0] ics_onehot(input logic [3:0] i);
        return NUM_MASK'(1) << i;
    endfunction : ics_onehot

    // Source order of flags: ext 1..3, timer, rx, tx, tdm rx, tdm tx, ext 4
    assign flag_set_w = {~ext_irq_n[3] & ext_prev_q[3], periph_irq,
                         ~ext_irq_n[2:0] & ext_prev_q[2:0]};
    assign ready_w    = flags_q & mask_q;

    // Instructions other than mask set and clear hold off hardware entry for their own cycle
    assign any_instr_w = soft_interrupt_instr | trap_instr
                       | nmi_trigger_instr | return_restore_instr
                       | return_restore_enable_instr | call_instr
                       | ret_instr | push_acc_instr | pop_acc_instr
                       | push_from_memory_instr | pop_to_memory_instr;
    assign ret_any_w   = return_restore_instr
                       | return_restore_enable_instr;

    // Arbitration: instructions, then nonmaskable, then masked flags
    always_comb begin
        take_idx_w = ics_first_set(ready_w);
        take_nmi_w = 1'b0;
        take_w     = 1'b1;
        take_vec_w = 5'h00;
        if (soft_interrupt_instr) begin
            take_vec_w = soft_vec;
        end else if (trap_instr) begin
            take_vec_w = `ICS_VEC_TRAP;
        end else if (nmi_trigger_instr) begin
            take_vec_w = `ICS_VEC_NMI;
        end else if (any_instr_w) begin
            take_w = 1'b0;
        end else if (nmi_pend_q) begin
            take_nmi_w = 1'b1;
            take_vec_w = `ICS_VEC_NMI;
        end else if (|ready_w && !global_irq_mask_q) begin
            take_vec_w = `ICS_VEC_FIRST_HW + 5'(take_idx_w);
        end else begin
            take_w = 1'b0;
        end
    end

    // Flags taken by hardware entry are cleared in the commit cycle
    assign flag_clr_w = (take_w && !any_instr_w && !take_nmi_w)
                      ? ics_onehot(take_idx_w) : '0;

    // Stack action selection; one source at a time
    always_comb begin
        push_w     = 1'b0;
        pop_w      = 1'b0;
        push_val_w = cur_pc;
        op_w       = ICS_STK_IDLE;
        if (take_w) begin
            op_w = ICS_STK_TAKE;
        end else if (call_instr) begin
            op_w = ICS_STK_PUSH;
        end else if (push_acc_instr) begin
            op_w       = ICS_STK_PUSH;
            push_val_w = push_value;
        end else if (push_from_memory_instr) begin
            op_w       = ICS_STK_PUSH;
            push_val_w = mem_rdata;
        end else if (ret_instr || ret_any_w) begin
            op_w = ICS_STK_POP;
        end else if (pop_acc_instr || pop_to_memory_instr) begin
            op_w = ICS_STK_PEEK;
        end
        case (op_w)
            ICS_STK_TAKE: push_w = 1'b1;
            ICS_STK_PUSH: push_w = 1'b1;
            ICS_STK_POP:  pop_w  = 1'b1;
            ICS_STK_PEEK: pop_w  = 1'b1;
            default:      pop_w  = 1'b0;
        endcase
    end

    // Live context gathered for the shadow save
    assign ctx_w[0]  = cur_acc;
    assign ctx_w[1]  = cur_accum_buffer;
    assign ctx_w[2]  = {16'h0000, cur_aux_compare_reg};
    assign ctx_w[3]  = {16'h0000, cur_index_reg};
    assign ctx_w[4]  = {16'h0000, cur_mode_status_reg};
    assign ctx_w[5]  = cur_product_reg;
    assign ctx_w[6]  = {16'h0000, cur_status_word_zero
                        & ~(16'h0001 << `ICS_ST0_GLOBAL_IRQ_MASK_BIT)};
    assign ctx_w[7]  = {16'h0000, cur_status_word_one
                        & ~(16'h0001 << `ICS_ST1_XF_BIT)};
    assign ctx_w[8]  = {16'h0000, cur_mult_temp_reg};
    assign ctx_w[9]  = {16'h0000, cur_shift_count_reg};
    assign ctx_w[10] = {16'h0000, cur_bit_test_reg};

    // Falling-edge detectors; idle high so a low at reset release counts
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_prev_q <= 4'hF;
            nmi_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= ext_irq_n;
            nmi_prev_q <= nmi_n;
        end
    end

    // Pending flags: a new edge beats any clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags_q    <= '0;
            nmi_pend_q <= 1'b0;
        end else begin
            flags_q <= (flags_q & ~flag_clr_w
                        & ~((reg_wr && reg_addr == `ICS_OFS_FLAGS)
                            ? reg_wdata[NUM_MASK-1:0] : '0))
                     | flag_set_w;
            if (!nmi_n && nmi_prev_q) begin
                nmi_pend_q <= 1'b1;
            end else if (take_nmi_w) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    // Global mask: entry sets it, enabling return clears it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            global_irq_mask_q <= 1'b1;
        end else if (take_w) begin
            global_irq_mask_q <= 1'b1;
        end else if (return_restore_enable_instr || clr_mask_instr) begin
            global_irq_mask_q <= 1'b0;
        end else if (set_mask_instr) begin
            global_irq_mask_q <= 1'b1;
        end
    end

    // Return stack by index; an overflow overwrites the oldest entry
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sp_q    <= '0;
            depth_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stk_q[i] <= 16'h0000;
            end
        end else if (push_w) begin
            sp_q        <= sp_q + 1'b1;
            stk_q[SPW'(sp_q + 1'b1)] <= push_val_w;
            if (depth_q != (SPW+1)'(STACK_DEPTH)) begin
                depth_q <= depth_q + 1'b1;
            end
        end else if (pop_w) begin
            sp_q <= sp_q - 1'b1;
            if (depth_q != '0) begin
                depth_q <= depth_q - 1'b1;
            end
        end
    end

    // Shadow copies: captured at commit, untouched otherwise
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `ICS_NUM_SHADOWS; i++) begin
                sh_q[i] <= 32'h0000_0000;
            end
        end else if (take_w) begin
            for (int i = 0; i < `ICS_NUM_SHADOWS; i++) begin
                sh_q[i] <= ctx_w[i];
            end
        end
    end

    // Entry and stack results; strobes last one cycle, vector_addr holds until the next entry
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_take      <= 1'b0;
            vector_addr   <= 16'h0000;
            pc_load       <= 1'b0;
            acc_load      <= 1'b0;
            mem_write     <= 1'b0;
            stack_data    <= 16'h0000;
            restore_valid <= 1'b0;
        end else begin
            irq_take      <= take_w;
            if (take_w) begin
                vector_addr <= {vecptr_q, 5'h00, take_vec_w, 1'b0};
            end
            pc_load       <= (ret_instr || ret_any_w) && !take_w;
            acc_load      <= pop_acc_instr && pop_w;
            mem_write     <= pop_to_memory_instr && pop_w;
            stack_data    <= stk_q[sp_q];
            // Working registers are not touched on entry, only here
            restore_valid <= ret_any_w && !take_w;
        end
    end

    // Software registers: mask and vector pointer field
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mask_q   <= `ICS_RST_MASK;
            vecptr_q <= `ICS_RST_VECPTR;
        end else if (reg_wr) begin
            if (reg_addr == `ICS_OFS_MASK) begin
                mask_q <= reg_wdata[NUM_MASK-1:0];
            end else if (reg_addr == `ICS_OFS_VECPTR) begin
                vecptr_q <= reg_wdata[4:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == `ICS_OFS_MASK) begin
            reg_rdata <= 32'(mask_q);
        end else if (reg_addr == `ICS_OFS_FLAGS) begin
            reg_rdata <= 32'(flags_q);
        end else if (reg_addr == `ICS_OFS_STATUS) begin
            reg_rdata <= 32'({depth_q, 2'b00, nmi_pend_q, global_irq_mask_q});
        end else if (reg_addr == `ICS_OFS_VECPTR) begin
            reg_rdata <= 32'(vecptr_q);
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Restored values come straight from the shadow flops
    assign global_irq_mask      = global_irq_mask_q;
    assign rst_acc              = sh_q[0];
    assign rst_accum_buffer     = sh_q[1];
    assign rst_aux_compare_reg  = sh_q[2][15:0];
    assign rst_index_reg        = sh_q[3][15:0];
    assign rst_mode_status_reg  = sh_q[4][15:0];
    assign rst_product_reg      = sh_q[5];
    assign rst_status_word_zero = sh_q[6][15:0];
    assign rst_status_word_one  = sh_q[7][15:0];
    assign rst_mult_temp_reg    = sh_q[8][15:0];
    assign rst_shift_count_reg  = sh_q[9][15:0];
    assign rst_bit_test_reg     = sh_q[10][15:0];

endmodule : ics_core

// [verif/ics_core_sva.sv]
/*
 * Concurrent checks on the ports of the interrupt context stack.
 * Assumes one clock, mclk, and the asynchronous active-low nrst.
 */
`timescale 1ns/1ps

module ics_core_sva (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        soft_interrupt_instr,
    input wire logic [4:0]  soft_vec,
    input wire logic        trap_instr,
    input wire logic        return_restore_instr,
    input wire logic        return_restore_enable_instr,
    input wire logic        set_mask_instr,
    input wire logic        clr_mask_instr,
    input wire logic        pop_acc_instr,
    input wire logic        pop_to_memory_instr,
    input wire logic [31:0] cur_acc,
    input wire logic [15:0] cur_status_word_zero,
    input wire logic [15:0] cur_status_word_one,
    input wire logic        irq_take,
    input wire logic [15:0] vector_addr,
    input wire logic        pc_load,
    input wire logic        acc_load,
    input wire logic        mem_write,
    input wire logic        global_irq_mask,
    input wire logic        restore_valid,
    input wire logic [31:0] rst_acc,
    input wire logic [15:0] rst_status_word_zero,
    input wire logic [15:0] rst_status_word_one
);
    default clocking cb_m @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Software entry lands on the vector it names
    chk_soft_vector: assert property (soft_interrupt_instr |=> irq_take &&
        vector_addr[5:1] == $past(soft_vec)) else $error("soft vector wrong");
    chk_trap_vector: assert property (trap_instr && !soft_interrupt_instr
        |=> irq_take && vector_addr[5:0] == 6'h22) else $error("trap vector");
    // Mask must already be up when the handler starts
    chk_take_mask: assert property (irq_take && !$past(clr_mask_instr)
        |-> global_irq_mask) else $error("mask not set on entry");
    chk_shadow_acc: assert property (irq_take |->
        rst_acc == $past(cur_acc)) else $error("acc shadow wrong");
    chk_shadow_excl: assert property (irq_take |->
        rst_status_word_zero == ($past(cur_status_word_zero) & 16'hFDFF) &&
        rst_status_word_one == ($past(cur_status_word_one) & 16'hFFEF))
        else $error("status shadow wrong");
    chk_shadow_hold: assert property (!irq_take |->
        $stable(rst_acc)) else $error("shadow moved without entry");
    chk_restore_out: assert property ((return_restore_instr ||
        return_restore_enable_instr) |=> restore_valid && pc_load)
        else $error("return without restore");
    chk_return_restore_enable_instr_unmask: assert property (return_restore_enable_instr &&
        !set_mask_instr |=> !global_irq_mask) else $error("mask kept");
    chk_pop_acc: assert property (pop_acc_instr |=>
        acc_load && !mem_write) else $error("pop to acc wrong");
    chk_pop_mem: assert property (pop_to_memory_instr |=>
        mem_write && !acc_load) else $error("pop to memory wrong");

    // Main traffic kinds
    cov_soft: cover property (soft_interrupt_instr ##1 irq_take);
    cov_ret: cover property (return_restore_enable_instr ##1 restore_valid);
    cov_popm: cover property (pop_to_memory_instr ##1 mem_write);
endmodule : ics_core_sva

bind ics_core ics_core_sva u_sva (.*);

// [verif/ics_irq_src.sv]
/*
 * Model of the outside devices raising requests on the core.
 * Assumes fire is a one-cycle pulse per source, driven from the bench.
 */
`timescale 1ns/1ps

module ics_irq_src (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic [9:0] fire,
    output logic [3:0]     ext_irq_n,
    output logic           nmi_n,
    output logic [4:0]     periph_irq
);
    // External and nonmaskable lines idle high; a request is one low cycle, enough for an edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_irq_n  <= 4'hF;
            nmi_n      <= 1'b1;
            periph_irq <= 5'h00;
        end else begin
            ext_irq_n  <= ~fire[3:0];
            periph_irq <= fire[8:4];
            nmi_n      <= ~fire[9];
        end
    end
endmodule : ics_irq_src

// [verif/testbench.sv]
/*
 * Self-checking bench for the interrupt context stack.
 * Assumes the design package, header and the request model are compiled.
 */
`timescale 1ns/1ps

module testbench;
    localparam int SI = 0, TR = 1, NT = 2, RI = 3, RE = 4, CL = 5, RT = 6;
    localparam int PA = 7, QA = 8, PM = 9, QM = 10, SM = 11, CM = 12;
    logic        mclk, nrst, reg_wr, reg_rd;
    logic [12:0] op;
    logic [9:0]  fire;
    logic [4:0]  soft_vec, periph_irq;
    logic [3:0]  ext_irq_n;
    logic        nmi_n, irq_take, pc_load, acc_load, mem_write;
    logic        global_irq_mask, restore_valid;
    logic [7:0]  reg_addr;
    logic [15:0] ctx, cur_pc, push_value, mem_rdata, vector_addr, stack_data;
    logic [31:0] reg_wdata, reg_rdata, rst_acc, rst_accum_buffer;
    logic [31:0] rst_product_reg;
    logic [15:0] rst_aux_compare_reg, rst_index_reg, rst_mode_status_reg;
    logic [15:0] rst_status_word_zero, rst_status_word_one, rst_mult_temp_reg;
    logic [15:0] rst_shift_count_reg, rst_bit_test_reg;
    int          n_errors, checks_done;
    // Strobes and context all derive from two bench variables
    wire soft_interrupt_instr = op[0], trap_instr = op[1];
    wire nmi_trigger_instr = op[2], return_restore_instr = op[3];
    wire return_restore_enable_instr = op[4], call_instr = op[5];
    wire ret_instr = op[6], push_acc_instr = op[7], pop_acc_instr = op[8];
    wire push_from_memory_instr = op[9], pop_to_memory_instr = op[10];
    wire set_mask_instr = op[11], clr_mask_instr = op[12];
    wire [31:0] cur_acc = {ctx, ~ctx}, cur_accum_buffer = {~ctx, ctx};
    wire [31:0] cur_product_reg = {ctx, ctx};
    wire [15:0] cur_aux_compare_reg = ctx ^ 16'h1111;
    wire [15:0] cur_index_reg = ctx ^ 16'h2222;
    wire [15:0] cur_mode_status_reg = ctx ^ 16'h3333;
    wire [15:0] cur_status_word_zero = ctx | 16'h0210;
    wire [15:0] cur_status_word_one = ctx | 16'h0210;
    wire [15:0] cur_mult_temp_reg = ctx ^ 16'h4444;
    wire [15:0] cur_shift_count_reg = ctx ^ 16'h5555;
    wire [15:0] cur_bit_test_reg = ctx ^ 16'h6666;

    ics_core dut (.*);
    ics_irq_src u_src (.*);

    task automatic cb(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask : cb
    task automatic cw(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : cw
    // One instruction strobe; returns inside the answer cycle
    task automatic ins(input int k);
        @(posedge mclk) op <= 13'(1) << k;
        @(posedge mclk) op <= '0;
        #1;
    endtask : ins
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk) reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk) reg_wr <= 1'b0;
    endtask : wr
    // Bounded wait so a lost request cannot hang the run
    task automatic wt();
        logic got;
        got = 1'b0;
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge mclk);
            #1 got = (irq_take === 1'b1);
        end
        cb("irq_take", 1'b1, got);
    endtask : wt

    task automatic t_reset();
        logic [31:0] d;
        cb("mask", 1'b1, global_irq_mask);
        rd(8'h08, d); cw("status", 32'h1, d);
        rd(8'h04, d); cw("flags", 32'h0, d);
        rd(8'h0C, d); cw("vecptr", 32'h0, d);
        cw("vector_addr", 32'h0, vector_addr);
        rd(8'h10, d); cw("unmapped", 32'h0, d);
    endtask : t_reset
    task automatic t_soft();
        for (int v = 0; v < 32; v++) begin
            @(posedge mclk) cur_pc <= 16'h1000 + 16'(v);
            soft_vec <= 5'(v);
            ins(SI);
            cw("soft vec", 32'(v) << 1, vector_addr);
            ins(RI);
            cb("pc_load", 1'b1, pc_load);
            cw("ret pc", 16'h1000 + 16'(v), stack_data);
        end
        // Fixed-vector instructions, taken with the mask up
        ins(TR);
        cw("trap vec", 32'h22, vector_addr);
        ins(RI);
        ins(NT);
        cw("nmi vec", 32'h24, vector_addr);
        ins(RI);
    endtask : t_soft
    task automatic t_stack();
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) cur_pc <= 16'h2000 + 16'(i);
            ins(CL);
        end
        rd(8'h08, d); cw("depth", 32'h81, d);
        for (int i = 7; i >= 0; i--) begin
            ins(RT); cw("lifo", 16'h2000 + 16'(i), stack_data);
        end
        @(posedge mclk) push_value <= 16'hBEEF;
        mem_rdata <= 16'hCAFE;
        ins(PA);
        ins(PM);
        ins(QM); cb("mem_write", 1'b1, mem_write);
        cw("pop mem", 32'hCAFE, stack_data);
        ins(QA); cb("acc_load", 1'b1, acc_load);
        cw("pop acc", 32'hBEEF, stack_data);
    endtask : t_stack
    task automatic t_hw();
        int vec[10] = '{1, 2, 3, 9, 4, 5, 6, 7, 8, 18};
        logic [15:0] e;
        wr(8'h00, 32'h1FF);
        ins(CM);
        for (int k = 0; k < 10; k++) begin
            @(posedge mclk) fire <= 10'(1) << k;
            ctx <= 16'h0101 * 16'(k + 1);
            cur_pc <= 16'h3000 + 16'(k);
            @(posedge mclk) fire <= '0;
            wt();
            e = ctx;
            ctx = ~ctx;
            cw("hw vec", 32'(vec[k]) << 1, vector_addr);
            cb("mask", 1'b1, global_irq_mask);
            cw("sh acc", {e, ~e}, rst_acc);
            cw("sh prod", {e, e}, rst_product_reg);
            cw("st0", e & 16'hFDFF | 16'h0010, rst_status_word_zero);
            cw("st1", e & 16'hFFEF | 16'h0200, rst_status_word_one);
            cw("sh abuf", {~e, e}, rst_accum_buffer);
            cw("sh cmp", e ^ 16'h1111, rst_aux_compare_reg);
            cw("sh idx", e ^ 16'h2222, rst_index_reg);
            cw("sh mode", e ^ 16'h3333, rst_mode_status_reg);
            cw("sh temp", e ^ 16'h4444, rst_mult_temp_reg);
            cw("sh shift", e ^ 16'h5555, rst_shift_count_reg);
            cw("sh bit", e ^ 16'h6666, rst_bit_test_reg);
            wr(8'h04, 32'hFFFF_FFFF);
            ins(RE); cb("restore", 1'b1, restore_valid);
            cw("ret pc", 16'h3000 + 16'(k), stack_data);
            cb("unmask", 1'b0, global_irq_mask);
        end
    endtask : t_hw
    task automatic t_masked();
        logic seen;
        seen = 1'b0;
        ins(SM);
        @(posedge mclk) fire <= 10'h002;
        @(posedge mclk) fire <= '0;
        repeat (8) begin
            @(posedge mclk);
            #1 seen = seen | (irq_take === 1'b1);
        end
        cb("held", 1'b0, seen);
        wr(8'h0C, 32'h0000_0003);
        ins(CM);
        wt();
        cw("late vec", 32'h0000_1804, vector_addr);
        wr(8'h04, 32'hFFFF_FFFF);
        ins(RE);
    endtask : t_masked

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Whole run is a few hundred cycles; far beyond that is a hang
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end
    initial begin
        {nrst, reg_wr, reg_rd, op, fire, soft_vec} = '0;
        {reg_addr, reg_wdata, cur_pc, push_value, mem_rdata} = '0;
        ctx = 16'h1234;
        n_errors = 0;
        checks_done = 0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_soft();
        t_stack();
        t_hw();
        t_masked();
        end_sim();
    end
endmodule : testbench
